// [rtl/smts_pkg.sv]
// Constants shared by the transfer sequencer.
package smts_pkg;

   // ==========================================================
   // Target codes
   localparam logic [15:0] TARGET_ONE_CODE = 16'h0000;
   localparam logic [15:0] TARGET_TWO_CODE = 16'h0001;
   localparam logic [15:0] TARGET_THREE_CODE = 16'h0002;

   // ==========================================================
   // Mode codes
   localparam logic [15:0] MODE_SEND = 16'h0000;
   localparam logic [15:0] MODE_RECEIVE = 16'h0001;
   localparam logic [15:0] MODE_DUPLEX = 16'h0002;

   // ==========================================================
   // Widths, reset values and fill data
   localparam int WORD_W_DEF = 8;
   localparam int ADDR_W = 16;
   localparam int CNT_W = 16;
   localparam logic [2:0] SEL_IDLE_N = 3'h7;
   localparam logic [7:0] DUMMY_WORD = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;

   typedef enum logic [2:0] {
      SMTS_IDLE, SMTS_SELECT, SMTS_FETCH, SMTS_WAIT_RD, SMTS_SHIFT,
      SMTS_STORE, SMTS_DESEL, SMTS_IRQ
   } smts_state_t;

endpackage

// [rtl/smts_sequencer.sv]
// SPI master transfer sequencer with its serial shifter on the link clock.
`timescale 1ns/1ps
// Functional notes
// [R1] Target code 0, 1 or 2 picks slave select one, two or three.
// [R2] Chosen select goes low before the first word moves.
// [R3] Chosen select goes high after the last word completes.
// [R4] After deselect a completion interrupt pulse is raised.
// [R5] Exactly the programmed count of words is transferred.
// [R6] Send mode: memory word sent, received word dropped, only transmit address advances.
// [R7] Receive mode: dummy sent, received word stored, only receive address advances.
// [R8] Duplex mode: memory word sent, received word stored, both addresses advance.
// [R9] Each word is fetched from memory before its serial transfer starts.
// [R10] Next step waits until the serial transfer reports completion.
// [R11] Software sets count, addresses, mode and target before triggering.
// [R12] Only a falling edge on the trigger input starts a sequence.
// [R13] The shifter is clock master, one word started at a time.
// [R14] Triggers during an active sequence are ignored until completion.
module smts_sequencer #(
   parameter int WORD_W = smts_pkg::WORD_W_DEF
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic spi_clk,
   input wire logic ext_trigger_irq,
   input wire logic [smts_pkg::CNT_W-1:0] cfg_count,
   input wire logic [15:0] cfg_mode,
   input wire logic [15:0] cfg_target,
   input wire logic [smts_pkg::ADDR_W-1:0] cfg_tx_addr,
   input wire logic [smts_pkg::ADDR_W-1:0] cfg_rx_addr,
   output logic mem_rd,
   output logic [smts_pkg::ADDR_W-1:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic [WORD_W-1:0] mem_rdata,
   output logic mem_wr,
   output logic [smts_pkg::ADDR_W-1:0] mem_wr_addr,
   output logic [WORD_W-1:0] mem_wdata,
   output logic slave_sel_1_n,
   output logic slave_sel_2_n,
   output logic slave_sel_3_n,
   output logic busy,
   output logic done_irq,
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   import smts_pkg::*;

   // ==========================================================
   // Declarations
   smts_state_t state;
   logic [2:0] trig_sync;
   logic trig_fall;
   logic cfg_ok;
   logic [15:0] mode;
   logic [CNT_W-1:0] remaining;
   logic [CNT_W-1:0] count_seen;
   logic [CNT_W-1:0] words_done;
   logic [ADDR_W-1:0] tx_ptr;
   logic [ADDR_W-1:0] rx_ptr;
   logic [WORD_W-1:0] tx_word;
   logic req_tog;
   logic ack_s1;
   logic ack_s2;
   logic ack_seen;
   logic ack_edge;
   logic [2:0] sel_n;
   logic lrst_s1;
   logic lrst;
   logic req_s1;
   logic req_s2;
   logic req_seen;
   logic lbusy;
   logic ack_tog;
   logic [WORD_W-1:0] shreg;
   logic [WORD_W-1:0] rx_word;
   logic [$clog2(WORD_W)-1:0] bitcnt;

   function automatic logic [2:0] smts_sel_decode(input logic [15:0] code);
      unique case (code)
         TARGET_ONE_CODE: smts_sel_decode = 3'h6;
         TARGET_TWO_CODE: smts_sel_decode = 3'h5;
         TARGET_THREE_CODE: smts_sel_decode = 3'h3;
         default: smts_sel_decode = SEL_IDLE_N;
      endcase
   endfunction

   function automatic logic smts_mode_ok(input logic [15:0] m);
      smts_mode_ok = (m == MODE_SEND) || (m == MODE_RECEIVE) || (m == MODE_DUPLEX);
   endfunction

   // ==========================================================
   // Trigger input
   // The pin is asynchronous, so two stages settle it before any edge is seen; the third holds the previous level.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trig_sync <= 3'h7;
      end else begin
         trig_sync <= {trig_sync[1:0], ext_trigger_irq};
      end
   end

   // [R12] Falling edge only.
   assign trig_fall = trig_sync[2] && !trig_sync[1];
   // [R1] Unknown codes never start.
   assign cfg_ok = smts_mode_ok(cfg_mode) && (smts_sel_decode(cfg_target) != SEL_IDLE_N);
   assign ack_edge = ack_s2 != ack_seen;

   // ==========================================================
   // Sequence control
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= SMTS_IDLE;
      end else begin
         unique case (state)
            // [R14] Trigger taken in idle only.
            SMTS_IDLE: begin
               if (trig_fall && cfg_ok) begin
                  state <= SMTS_SELECT;
               end
            end
            SMTS_SELECT: begin
               state <= (remaining == '0) ? SMTS_DESEL : SMTS_FETCH;
            end
            // [R9] Fetch before shift.
            SMTS_FETCH: state <= SMTS_WAIT_RD;
            SMTS_WAIT_RD: begin
               if (mem_rd_ack) begin
                  state <= SMTS_SHIFT;
               end
            end
            // [R10] Wait for completion.
            SMTS_SHIFT: begin
               if (ack_edge) begin
                  state <= SMTS_STORE;
               end
            end
            // [R5] Stop after the last word.
            SMTS_STORE: begin
               state <= (remaining == CNT_W'(1)) ? SMTS_DESEL : SMTS_FETCH;
            end
            SMTS_DESEL: state <= SMTS_IRQ;
            SMTS_IRQ: state <= SMTS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Latched parameters and pointers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode <= MODE_SEND;
         remaining <= '0;
         count_seen <= '0;
         tx_ptr <= '0;
         rx_ptr <= '0;
      end else if (state == SMTS_IDLE && trig_fall && cfg_ok) begin
         mode <= cfg_mode;
         remaining <= cfg_count;
         count_seen <= cfg_count;
         tx_ptr <= cfg_tx_addr;
         rx_ptr <= cfg_rx_addr;
      end else if (state == SMTS_STORE) begin
         remaining <= remaining - CNT_W'(1);
         // [R6] Send advances transmit only.
         // [R7] Receive advances receive only.
         // [R8] Duplex advances both.
         if (mode != MODE_RECEIVE) begin
            tx_ptr <= tx_ptr + ADDR_STEP;
         end
         if (mode != MODE_SEND) begin
            rx_ptr <= rx_ptr + ADDR_STEP;
         end
      end
   end

   // ==========================================================
   // Memory side
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_rd <= 1'b0;
         mem_rd_addr <= '0;
         mem_wr <= 1'b0;
         mem_wr_addr <= '0;
         mem_wdata <= '0;
      end else begin
         mem_rd <= state == SMTS_FETCH;
         mem_rd_addr <= tx_ptr;
         // [R6] Received word dropped in send mode.
         mem_wr <= (state == SMTS_STORE) && (mode != MODE_SEND);
         mem_wr_addr <= rx_ptr;
         // The link word is read only after its toggle has crossed, never while it moves.
         if (state == SMTS_STORE) begin
            mem_wdata <= rx_word;
         end
      end
   end

   // ==========================================================
   // Word handover to the shifter
   // The word is held until the acknowledge returns, so the link side reads it stable.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_word <= '0;
         req_tog <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_seen <= 1'b0;
      end else begin
         ack_s1 <= ack_tog;
         ack_s2 <= ack_s1;
         if (state == SMTS_SHIFT && ack_edge) begin
            ack_seen <= ack_s2;
         end
         if (state == SMTS_WAIT_RD && mem_rd_ack) begin
            // [R7] Dummy data in receive mode.
            tx_word <= (mode == MODE_RECEIVE) ? DUMMY_WORD[WORD_W-1:0] : mem_rdata;
            // [R13] One word started at a time.
            req_tog <= ~req_tog;
         end
      end
   end

   // ==========================================================
   // Selects and status
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sel_n <= SEL_IDLE_N;
         busy <= 1'b0;
         done_irq <= 1'b0;
      end else begin
         // [R2] Select on start.
         if (state == SMTS_IDLE && trig_fall && cfg_ok) begin
            sel_n <= smts_sel_decode(cfg_target);
         // [R3] Deselect after the last word.
         end else if (state == SMTS_DESEL) begin
            sel_n <= SEL_IDLE_N;
         end
         busy <= !(state == SMTS_IDLE || state == SMTS_IRQ);
         // [R4] Interrupt one cycle after deselect.
         done_irq <= state == SMTS_IRQ;
      end
   end

   assign slave_sel_1_n = sel_n[0];
   assign slave_sel_2_n = sel_n[1];
   assign slave_sel_3_n = sel_n[2];

   // ==========================================================
   // Link domain
   always_ff @(posedge spi_clk or posedge reset) begin
      if (reset) begin
         lrst_s1 <= 1'b1;
         lrst <= 1'b1;
      end else begin
         lrst_s1 <= 1'b0;
         lrst <= lrst_s1;
      end
   end

   // [R13] Shifter drives the serial clock, mode 0 timing, half a bit per edge.
   always_ff @(posedge spi_clk or posedge lrst) begin
      if (lrst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_seen <= 1'b0;
         lbusy <= 1'b0;
         ack_tog <= 1'b0;
         shreg <= '0;
         rx_word <= '0;
         bitcnt <= '0;
         sck <= 1'b0;
         mosi <= 1'b0;
      end else begin
         req_s1 <= req_tog;
         req_s2 <= req_s1;
         if (!lbusy) begin
            if (req_s2 != req_seen) begin
               req_seen <= req_s2;
               lbusy <= 1'b1;
               shreg <= tx_word;
               mosi <= tx_word[WORD_W-1];
               bitcnt <= '0;
            end
         end else if (!sck) begin
            sck <= 1'b1;
            shreg <= {shreg[WORD_W-2:0], miso};
         end else begin
            sck <= 1'b0;
            if (bitcnt == ($clog2(WORD_W))'(WORD_W - 1)) begin
               lbusy <= 1'b0;
               rx_word <= shreg;
               ack_tog <= ~ack_tog;
            end else begin
               bitcnt <= bitcnt + 1'b1;
               mosi <= shreg[WORD_W-1];
            end
         end
      end
   end

   // ==========================================================
   // Checks
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         words_done <= '0;
      end else if (state == SMTS_SELECT) begin
         words_done <= '0;
      end else if (state == SMTS_STORE) begin
         words_done <= words_done + CNT_W'(1);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_deselect;
      $rose(&sel_n);
   endsequence

   sequence s_irq_pulse;
      done_irq ##1 !done_irq;
   endsequence

   a_sel_one_low: assert property ($countones(~sel_n) <= 1) // [R1]
      else $error("more than one slave selected");
   a_sel_before_fetch: assert property (mem_rd |-> (sel_n != SEL_IDLE_N)) // [R2]
      else $error("memory read without a selected slave");
   a_deselect_irq: assert property (s_deselect |=> s_irq_pulse) // [R3]
      else $error("deselect not followed by one interrupt pulse");
   a_irq_after_desel: assert property (done_irq |-> (&sel_n) && $past(&sel_n)) // [R4]
      else $error("interrupt raised while a slave is selected");
   a_word_count: assert property (done_irq |-> words_done == count_seen) // [R5]
      else $error("word count differs from programmed count");
   a_send_no_store: assert property (mem_wr |-> mode != MODE_SEND) // [R6]
      else $error("store issued in send mode");
   a_recv_dummy: assert property ($changed(req_tog) && mode == MODE_RECEIVE
      |-> tx_word == DUMMY_WORD[WORD_W-1:0]) // [R7]
      else $error("receive mode sent non dummy data");
   a_duplex_step: assert property (state == SMTS_STORE && mode == MODE_DUPLEX
      |=> tx_ptr == $past(tx_ptr) + ADDR_STEP && rx_ptr == $past(rx_ptr) + ADDR_STEP) // [R8]
      else $error("duplex pointers did not both advance");
   a_fetch_first: assert property ($changed(req_tog) |-> $past(mem_rd_ack)
      && $past(state) == SMTS_WAIT_RD) // [R9]
      else $error("word started without a fetched word");
   a_wait_done: assert property (state == SMTS_STORE |-> $past(state) == SMTS_SHIFT
      && $past(ack_edge)) // [R10]
      else $error("store before transfer completion");
   a_start_edge: assert property (state == SMTS_IDLE && !trig_fall |=> state == SMTS_IDLE) // [R12]
      else $error("sequence started without a falling edge");
   a_busy_ignore: assert property (state != SMTS_IDLE && state != SMTS_IRQ
      |=> state != SMTS_SELECT) // [R14]
      else $error("trigger accepted during a sequence");
   a_cfg_hold: assert property (state != SMTS_IDLE
      |=> $stable(count_seen) && $stable(mode)) // [R14]
      else $error("configuration reloaded during a sequence");

   a_mosi_stable: assert property (@(posedge spi_clk) disable iff (lrst)
      sck |-> $stable(mosi)) // [R13]
      else $error("data changed while serial clock high");

endmodule // smts_sequencer

// [verification/smts_sequencer_tb.sv]
// Self-checking bench for the transfer sequencer.
`timescale 1ns/1ps
module smts_sequencer_tb;
   import smts_pkg::*;
   // ====================
   // Stimulus and observation
   logic sys_clk = 1'b0;
   logic spi_clk = 1'b0;
   logic reset = 1'b1;
   logic trig = 1'b1;
   logic [15:0] cnt = 16'h0000;
   logic [15:0] mode = 16'h0000;
   logic [15:0] tgt = 16'h0000;
   logic [15:0] tx_a = 16'h0000;
   logic [15:0] rx_a = 16'h0000;
   logic mem_rd_ack = 1'b0;
   logic [7:0] mem_rdata = 8'h00;
   logic idle_t = 1'b0;
   logic mem_rd;
   logic mem_wr;
   logic busy;
   logic done_irq;
   logic sck;
   logic mosi;
   logic miso;
   logic [15:0] rd_addr;
   logic [15:0] wr_addr;
   logic [7:0] wdata;
   logic [2:0] sel_n;
   logic [2:0] s_miso;
   logic [7:0] s_rx [3];
   int s_words [3];
   int error_cnt = 0;
   int cmp_count = 0;
   always #12.5 sys_clk = ~sys_clk;
   initial begin
      #3.3;
      forever #7.5 spi_clk = ~spi_clk;
   end
   // A released data line must not look like a valid answer, so it toggles.
   always @(posedge spi_clk) idle_t <= ~idle_t;
   assign miso = !sel_n[0] ? s_miso[0] : !sel_n[1] ? s_miso[1] : !sel_n[2] ? s_miso[2] : idle_t;
   always @(posedge sys_clk) begin
      mem_rd_ack <= mem_rd;
      mem_rdata <= rd_addr[7:0] ^ 8'h5a;
   end
   smts_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .spi_clk(spi_clk),
      .ext_trigger_irq(trig), .cfg_count(cnt), .cfg_mode(mode), .cfg_target(tgt),
      .cfg_tx_addr(tx_a), .cfg_rx_addr(rx_a), .mem_rd(mem_rd), .mem_rd_addr(rd_addr),
      .mem_rd_ack(mem_rd_ack), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wr_addr(wr_addr),
      .mem_wdata(wdata), .slave_sel_1_n(sel_n[0]), .slave_sel_2_n(sel_n[1]),
      .slave_sel_3_n(sel_n[2]), .busy(busy), .done_irq(done_irq), .sck(sck), .mosi(mosi),
      .miso(miso));
   for (genvar i = 0; i < 3; i++) begin : g_slv
      smts_slave_model #(.ANSWER(8'h5b + 8'(i) * 8'h33)) slave_u (.sel_n(sel_n[i]), .sck(sck),
         .mosi(mosi), .miso(s_miso[i]), .last_rx(s_rx[i]), .words(s_words[i]));
   end
   // ====================
   // Checking helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] etx(input logic [15:0] m, input logic [15:0] a);
      return (m == MODE_RECEIVE) ? DUMMY_WORD : a[7:0] ^ 8'h5a;
   endfunction
   // ====================
   // Scenarios
   task automatic run_seq(input logic [15:0] m, input logic [15:0] t, input logic [15:0] c,
      input bit x);
      int nrd;
      int nwr;
      int w0;
      int cyc;
      logic [2:0] en;
      logic [7:0] ans;
      logic [15:0] txb;
      logic [15:0] rxb;
      nrd = 0;
      nwr = 0;
      cyc = 0;
      w0 = s_words[t];
      en = ~(3'h1 << t);
      ans = 8'h5b + 8'(t) * 8'h33;
      txb = 16'h0040 + t;
      rxb = 16'h0a00 + m;
      @(posedge sys_clk);
      cnt <= c;
      mode <= m;
      tgt <= t;
      tx_a <= txb;
      rx_a <= rxb;
      repeat (2) @(posedge sys_clk);
      trig <= 1'b0;
      while (cyc < 200 + 60 * int'(c)) begin
         @(posedge sys_clk);
         cyc++;
         if ((cyc == 5 && !x) || (x && cyc == 40)) trig <= 1'b1;
         if (x && cyc == 50) trig <= 1'b0;
         #1;
         if (mem_rd) begin
            chk(sel_n, en);
            chk(busy, 1'b1);
            chk(s_words[t] - w0, nrd);
            if (nrd > 0) chk(s_rx[t], etx(m, txb + nrd - 1));
            chk(rd_addr, txb + (m == MODE_RECEIVE ? 0 : nrd));
            nrd++;
         end
         if (mem_wr) begin
            chk(wr_addr, rxb + nwr);
            chk(wdata, ans);
            nwr++;
         end
         if (done_irq) break;
      end
      chk(done_irq, 1'b1);
      chk(sel_n, 3'h7);
      chk(nrd, c);
      chk(nwr, m == MODE_SEND ? 16'h0000 : c);
      if (c > 0) chk(s_rx[t], etx(m, txb + c - 1));
      @(posedge sys_clk);
      trig <= 1'b1;
      repeat (30) @(posedge sys_clk);
      #1;
      chk(busy, 1'b0);
      chk(s_words[t] - w0, c);
      $display("sequence mode %0h target %0h count %0h finished", m, t, c);
   endtask
   task automatic bad_codes();
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         mode <= i ? MODE_SEND : 16'h0003;
         tgt <= i ? 16'h0003 : TARGET_ONE_CODE;
         repeat (2) @(posedge sys_clk);
         trig <= 1'b0;
         repeat (5) @(posedge sys_clk);
         trig <= 1'b1;
         repeat (20) @(posedge sys_clk);
         #1;
         chk(sel_n, 3'h7);
         chk(busy, 1'b0);
      end
      $display("invalid code test finished");
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ====================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int t = 0; t < 3; t++) begin
         for (int m = 0; m < 3; m++) begin
            run_seq(16'(m), 16'(t), 16'h0003, 1'b0);
         end
      end
      run_seq(MODE_DUPLEX, TARGET_TWO_CODE, 16'h0000, 1'b0);
      run_seq(MODE_DUPLEX, TARGET_THREE_CODE, 16'h0004, 1'b1);
      bad_codes();
      tally_and_finish();
   end
   // The full run needs about 30 us, so this leaves a wide margin.
   initial begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end
endmodule // smts_sequencer_tb

// [verification/smts_slave_model.sv]
// Behavioural SPI slave that answers one fixed byte for every word.
`timescale 1ns/1ps
module smts_slave_model #(
   parameter logic [7:0] ANSWER = 8'ha5
) (
   input wire logic sel_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic [7:0] last_rx,
   output int words
);
   logic [7:0] tx_sh = ANSWER;
   logic [7:0] rx_sh = 8'h00;
   int bits = 0;
   initial words = 0;
   initial last_rx = 8'h00;
   // The bench mux replaces this level whenever the slave is not selected.
   assign miso = tx_sh[7];
   always @(posedge sck) begin
      if (!sel_n) begin
         rx_sh = {rx_sh[6:0], mosi};
         bits++;
         if (bits == 8) begin
            last_rx = rx_sh;
            words++;
            bits = 0;
         end
      end
   end
   always @(negedge sck) begin
      if (!sel_n) begin
         tx_sh = {tx_sh[6:0], tx_sh[7]};
      end
   end
   // A deselect aborts any half word, as a real slave would.
   always @(posedge sel_n) begin
      bits = 0;
      tx_sh = ANSWER;
   end
endmodule // smts_slave_model
